// ### core/balu_pkg.sv
// package: register map, field layout, opcodes and reset values for the byte alu
package balu_pkg;
  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [11:0] BALU_ACC_OFS = 12'h000;
  localparam logic [11:0] BALU_STATUS_OFS = 12'h004;
  localparam logic [11:0] BALU_PTR0_OFS = 12'h008;
  localparam logic [11:0] BALU_PTR1_OFS = 12'h00C;
  localparam logic [11:0] BALU_EXEC_OFS = 12'h010;
  localparam logic [11:0] BALU_FILE_BASE = 12'h200;
  localparam logic [11:0] BALU_FILE_END = 12'h3FC;
  localparam int BALU_FILE_DEPTH = 128;

  // ************************************************************
  // status register fields
  // ************************************************************
  localparam int BALU_ST_C_POS = 0;
  localparam int BALU_ST_DC_POS = 1;
  localparam int BALU_ST_Z_POS = 2;
  localparam int BALU_ST_BUSY_POS = 8;
  localparam int BALU_ST_CYC_LSB = 16;

  // ************************************************************
  // exec register fields
  // ************************************************************
  localparam int BALU_EX_OP_LSB = 0;
  localparam int BALU_EX_DEST_POS = 3;
  localparam int BALU_EX_FLOW_POS = 4;
  localparam int BALU_EX_OPND_LSB = 8;
  localparam int BALU_EX_PSEL_POS = 14;

  // ************************************************************
  // opcodes, indirect locations, reset values
  // ************************************************************
  localparam logic [2:0] BALU_OP_POINTER_ADD_LITERAL = 3'h0;
  localparam logic [2:0] BALU_OP_ACC_ADD_IMMEDIATE = 3'h1;
  localparam logic [2:0] BALU_OP_ACC_ADD_FILE = 3'h2;
  localparam logic [2:0] BALU_OP_ACC_ADD_FILE_WITH_CARRY = 3'h3;
  localparam logic [2:0] BALU_OP_ACC_AND_IMMEDIATE = 3'h4;
  localparam logic [2:0] BALU_OP_ACC_AND_FILE = 3'h5;
  localparam logic [2:0] BALU_OP_ARITH_SHIFT_RIGHT_FILE = 3'h6;
  localparam logic [2:0] BALU_OP_IDLE_CYCLE = 3'h7;
  localparam logic [6:0] BALU_INDIRECT_LOC0 = 7'h00;
  localparam logic [6:0] BALU_INDIRECT_LOC1 = 7'h01;
  localparam logic [7:0] BALU_ACC_RST = 8'h00;
  localparam logic [15:0] BALU_PTR_RST = 16'h0000;
  localparam logic [1:0] BALU_CYC_ONE = 2'h1;

  typedef struct packed {
    logic carry;
    logic digit_carry_flag;
    logic zero;
  } balu_flags_t;

  typedef struct packed {
    logic [2:0] op;
    logic dest;
    logic flow_change;
    logic [7:0] opnd;
  } balu_instr_t;

  typedef enum logic [2:0] {
    BALU_ST_IDLE = 3'b001,
    BALU_ST_EXEC = 3'b010,
    BALU_ST_STALL = 3'b100
  } balu_state_t;
endpackage

// ### core/balu_core.sv
// byte alu datapath with apb register access and instruction cycle accounting
// Function
// - pc change or true test: two cycles
// - indirect access, pointer msb set: extra cycle
// - pointer add signed literal, flags unchanged
// - pointer pair wraps modulo 16 bits
// - add immediate into accumulator, c dc z
// - destination bit: 0 accumulator, 1 file
// - add accumulator and file register, c dc z
// - add accumulator, file and carry, c dc z
// - and immediate into accumulator, zero only
// - and file register, routed, zero only
// - shift right, bit 0 into carry
// - shift keeps original sign bit
module balu_core (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);
  import balu_pkg::*;

  // ************************************************************
  // state
  // ************************************************************
  balu_state_t state_q;
  balu_instr_t ins_q;
  balu_flags_t flags_q;
  logic [7:0] acc_q;
  logic [15:0] ptr0_q;
  logic [15:0] ptr1_q;
  logic [7:0] file_mem [BALU_FILE_DEPTH];
  logic [1:0] stall_q;
  logic [1:0] cyc_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic busy_q;

  // ************************************************************
  // apb decode
  // ************************************************************
  logic apb_done;
  logic apb_wr;
  logic in_file;
  logic mapped;
  logic [6:0] file_idx;
  assign apb_done = psel & penable & pready_q;
  assign in_file = (paddr >= BALU_FILE_BASE) && (paddr <= BALU_FILE_END) && (paddr[1:0] == 2'h0);
  assign file_idx = paddr[8:2];
  assign mapped = in_file || paddr == BALU_ACC_OFS || paddr == BALU_STATUS_OFS ||
                  paddr == BALU_PTR0_OFS || paddr == BALU_PTR1_OFS || paddr == BALU_EXEC_OFS;
  // writes while busy are refused so software never races the datapath
  assign apb_wr = apb_done & pwrite & mapped & ~busy_q;

  // ************************************************************
  // operand fetch and alu
  // ************************************************************
  logic [6:0] eff_addr;
  logic ind_hit;
  logic [7:0] opnd;
  logic [7:0] result;
  logic res_c;
  logic res_dc;
  logic to_file;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic cin;
  logic [15:0] ptr_sel;
  logic [15:0] ptr_next;
  logic [1:0] extra;
  logic is_imm;

  always_comb begin
    ptr_sel = ins_q.opnd[6] ? ptr1_q : ptr0_q;
    is_imm = ins_q.op == BALU_OP_ACC_ADD_IMMEDIATE || ins_q.op == BALU_OP_ACC_AND_IMMEDIATE ||
             ins_q.op == BALU_OP_POINTER_ADD_LITERAL || ins_q.op == BALU_OP_IDLE_CYCLE;
    ind_hit = 1'b0;
    eff_addr = ins_q.opnd[6:0];
    if (!is_imm && ins_q.opnd[6:0] == BALU_INDIRECT_LOC0) begin
      eff_addr = ptr0_q[6:0];
      ind_hit = ptr0_q[15];
    end else if (!is_imm && ins_q.opnd[6:0] == BALU_INDIRECT_LOC1) begin
      eff_addr = ptr1_q[6:0];
      ind_hit = ptr1_q[15];
    end
    opnd = is_imm ? ins_q.opnd : file_mem[eff_addr];
    cin = (ins_q.op == BALU_OP_ACC_ADD_FILE_WITH_CARRY) ? flags_q.carry : 1'b0;
    sum9 = {1'b0, acc_q} + {1'b0, opnd} + {8'h00, cin};
    sum5 = {1'b0, acc_q[3:0]} + {1'b0, opnd[3:0]} + {4'h0, cin};
    ptr_next = ptr_sel + {{10{ins_q.opnd[5]}}, ins_q.opnd[5:0]};
    result = sum9[7:0];
    res_c = sum9[8];
    res_dc = sum5[4];
    unique case (ins_q.op)
      BALU_OP_ACC_AND_IMMEDIATE, BALU_OP_ACC_AND_FILE: begin
        result = acc_q & opnd;
        res_c = flags_q.carry;
        res_dc = flags_q.digit_carry_flag;
      end
      BALU_OP_ARITH_SHIFT_RIGHT_FILE: begin
        result = {opnd[7], opnd[7:1]};
        res_c = opnd[0];
        res_dc = flags_q.digit_carry_flag;
      end
      default: begin
      end
    endcase
    to_file = ins_q.dest && (ins_q.op == BALU_OP_ACC_ADD_FILE ||
              ins_q.op == BALU_OP_ACC_ADD_FILE_WITH_CARRY || ins_q.op == BALU_OP_ACC_AND_FILE ||
              ins_q.op == BALU_OP_ARITH_SHIFT_RIGHT_FILE);
    extra = {1'b0, ins_q.flow_change} + {1'b0, ind_hit};
  end

  logic exec;
  logic alu_op;
  assign exec = state_q == BALU_ST_EXEC;
  assign alu_op = ins_q.op != BALU_OP_POINTER_ADD_LITERAL && ins_q.op != BALU_OP_IDLE_CYCLE;

  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q <= BALU_ST_IDLE;
      stall_q <= 2'h0;
      cyc_q <= BALU_CYC_ONE;
    end else begin
      unique case (state_q)
        BALU_ST_IDLE: begin
          if (apb_wr && paddr == BALU_EXEC_OFS) begin
            state_q <= BALU_ST_EXEC;
          end
        end
        BALU_ST_EXEC: begin
          // the trailing cycles only occupy time, like an idle_cycle
          stall_q <= extra;
          cyc_q <= BALU_CYC_ONE + extra;
          state_q <= (extra != 2'h0) ? BALU_ST_STALL : BALU_ST_IDLE;
        end
        BALU_ST_STALL: begin
          stall_q <= stall_q - 2'h1;
          if (stall_q == 2'h1) begin
            state_q <= BALU_ST_IDLE;
          end
        end
        default: begin
          state_q <= BALU_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q == BALU_ST_IDLE) ? (apb_wr && paddr == BALU_EXEC_OFS)
                : !(state_q == BALU_ST_STALL && stall_q == 2'h1) && !(exec && extra == 2'h0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ins_q <= '0;
    end else if (apb_wr && paddr == BALU_EXEC_OFS) begin
      ins_q.op <= pwdata[BALU_EX_OP_LSB +: 3];
      ins_q.dest <= pwdata[BALU_EX_DEST_POS];
      ins_q.flow_change <= pwdata[BALU_EX_FLOW_POS];
      ins_q.opnd <= pwdata[BALU_EX_OPND_LSB +: 8];
    end
  end

  // ************************************************************
  // architectural registers
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      acc_q <= BALU_ACC_RST;
    end else if (exec && alu_op && !to_file) begin
      acc_q <= result;
    end else if (apb_wr && paddr == BALU_ACC_OFS) begin
      acc_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flags_q <= '0;
    end else if (exec && alu_op) begin
      flags_q.carry <= res_c;
      flags_q.digit_carry_flag <= res_dc;
      flags_q.zero <= result == 8'h00;
    end else if (apb_wr && paddr == BALU_STATUS_OFS) begin
      flags_q.carry <= pwdata[BALU_ST_C_POS];
      flags_q.digit_carry_flag <= pwdata[BALU_ST_DC_POS];
      flags_q.zero <= pwdata[BALU_ST_Z_POS];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ptr0_q <= BALU_PTR_RST;
      ptr1_q <= BALU_PTR_RST;
    end else if (exec && ins_q.op == BALU_OP_POINTER_ADD_LITERAL) begin
      if (ins_q.opnd[6]) begin
        ptr1_q <= ptr_next;
      end else begin
        ptr0_q <= ptr_next;
      end
    end else if (apb_wr && paddr == BALU_PTR0_OFS) begin
      ptr0_q <= pwdata[15:0];
    end else if (apb_wr && paddr == BALU_PTR1_OFS) begin
      ptr1_q <= pwdata[15:0];
    end
  end

  // file storage holds data only, so it is left without reset
  always_ff @(posedge sys_clk) begin
    if (exec && to_file) begin
      file_mem[eff_addr] <= result;
    end else if (apb_wr && in_file) begin
      file_mem[file_idx] <= pwdata[7:0];
    end
  end

  // ************************************************************
  // apb answer: one wait state in every access
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & (~mapped | (pwrite & busy_q));
      prdata_q <= 32'h0000_0000;
      if (psel && penable && !pready_q && !pwrite) begin
        if (in_file) begin
          prdata_q <= {24'h000000, file_mem[file_idx]};
        end else if (paddr == BALU_ACC_OFS) begin
          prdata_q <= {24'h000000, acc_q};
        end else if (paddr == BALU_STATUS_OFS) begin
          prdata_q <= {14'h0000, cyc_q, 7'h00, busy_q, 5'h00, flags_q.zero,
                       flags_q.digit_carry_flag, flags_q.carry};
        end else if (paddr == BALU_PTR0_OFS) begin
          prdata_q <= {16'h0000, ptr0_q};
        end else if (paddr == BALU_PTR1_OFS) begin
          prdata_q <= {16'h0000, ptr1_q};
        end
      end
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign busy = busy_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_exec_flow;
    exec && ins_q.flow_change && !ind_hit;
  endsequence
  sequence s_one_stall;
    state_q == BALU_ST_STALL ##1 state_q == BALU_ST_IDLE;
  endsequence

  a_flow_two_cycle: assert property (@(posedge sys_clk) disable iff (reset)
    s_exec_flow |=> s_one_stall) else $error("flow change did not take two cycles");
  a_indirect_extra: assert property (@(posedge sys_clk) disable iff (reset)
    exec && ind_hit && !ins_q.flow_change |=> state_q == BALU_ST_STALL ##1 !busy_q)
    else $error("indirect access missed its extra cycle");
  a_ptr_add_wrap: assert property (@(posedge sys_clk) disable iff (reset)
    exec && ins_q.op == BALU_OP_POINTER_ADD_LITERAL && !ins_q.opnd[6] |=>
    ptr0_q == 16'($past(ptr0_q) + {{10{$past(ins_q.opnd[5])}}, $past(ins_q.opnd[5:0])}))
    else $error("pointer add result wrong");
  a_ptr_flags_hold: assert property (@(posedge sys_clk) disable iff (reset)
    exec && ins_q.op == BALU_OP_POINTER_ADD_LITERAL |=> $stable(flags_q) && $stable(acc_q))
    else $error("pointer add touched flags");
  a_add_imm_sum: assert property (@(posedge sys_clk) disable iff (reset)
    exec && ins_q.op == BALU_OP_ACC_ADD_IMMEDIATE |=>
    {flags_q.carry, acc_q} == 9'({1'b0, $past(acc_q)} + {1'b0, $past(ins_q.opnd)}))
    else $error("add immediate wrong");
  a_dest_file_keep: assert property (@(posedge sys_clk) disable iff (reset)
    exec && to_file |=> $stable(acc_q)) else $error("file destination changed accumulator");
  a_and_keep_c: assert property (@(posedge sys_clk) disable iff (reset)
    exec && (ins_q.op == BALU_OP_ACC_AND_FILE || ins_q.op == BALU_OP_ACC_AND_IMMEDIATE) |=>
    $stable(flags_q.carry) && $stable(flags_q.digit_carry_flag)) else $error("and changed carry");
  a_asr_sign_keep: assert property (@(posedge sys_clk) disable iff (reset)
    exec && ins_q.op == BALU_OP_ARITH_SHIFT_RIGHT_FILE && !ins_q.dest |=>
    acc_q[7] == acc_q[6] && flags_q.carry == $past(opnd[0])) else $error("shift lost sign");
  a_zero_flag: assert property (@(posedge sys_clk) disable iff (reset)
    exec && alu_op && !to_file |=> flags_q.zero == (acc_q == 8'h00))
    else $error("zero flag wrong");
endmodule

// ### sim/tb_top.sv
// self-checking testbench for the byte alu core, driven over apb
module tb_top import balu_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic busy;
  logic [31:0] n;
  int err_count = 0;
  int cmp_count = 0;

  balu_core balu_core_inst (.sys_clk(sys_clk), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busy(busy));

  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic stop_test();
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // entered just after an edge; leaves the request up so a caller may chain transfers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int k;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge sys_clk);
      if (pready === 1'b1) break;
    end
    if (k == 20) chk(32'h0, 32'h1);
    r = prdata;
    e = pslverr;
  endtask

  // lets one idle edge pass so the next request never reassigns psel in the same step
  task automatic rel();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
    rel();
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    rel();
    chk(r & m, x);
  endtask

  task automatic st(input logic [2:0] f, input logic [1:0] c);
    rdc(BALU_STATUS_OFS, 32'h0003_0007, {14'h0, c, 13'h0, f});
  endtask

  function automatic logic [11:0] fa(input int i);
    return BALU_FILE_BASE + 12'(4 * i);
  endfunction

  // counts busy cycles so the instruction length is judged at the pins too
  task automatic ex(input logic [2:0] op, input logic dst, input logic flw,
    input logic [7:0] opnd, output logic [31:0] cnt);
    wr(BALU_EXEC_OFS, {16'h0, opnd, 3'h0, flw, dst, op});
    cnt = 32'h0;
    repeat (20) begin
      if (busy !== 1'b1) break;
      cnt++;
      @(posedge sys_clk);
    end
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_ptr();
    wr(BALU_STATUS_OFS, 32'h7);
    wr(BALU_PTR0_OFS, 32'hFFFE);
    ex(BALU_OP_POINTER_ADD_LITERAL, 1'b0, 1'b0, 8'h03, n);
    chk(n, 32'h1);
    rdc(BALU_PTR0_OFS, 32'hFFFF, 32'h0001);
    wr(BALU_PTR1_OFS, 32'h0010);
    ex(BALU_OP_POINTER_ADD_LITERAL, 1'b0, 1'b0, 8'h60, n);
    rdc(BALU_PTR1_OFS, 32'hFFFF, 32'hFFF0);
    st(3'h7, 2'h1);
  endtask

  task automatic t_add();
    wr(BALU_STATUS_OFS, 32'h0);
    wr(BALU_ACC_OFS, 32'h8F);
    ex(BALU_OP_ACC_ADD_IMMEDIATE, 1'b0, 1'b0, 8'h71, n);
    rdc(BALU_ACC_OFS, 32'hFF, 32'h00);
    st(3'h7, 2'h1);
    wr(BALU_STATUS_OFS, 32'h0);
    wr(fa(5), 32'h0A);
    wr(BALU_ACC_OFS, 32'h06);
    ex(BALU_OP_ACC_ADD_FILE, 1'b0, 1'b0, 8'h05, n);
    rdc(BALU_ACC_OFS, 32'hFF, 32'h10);
    st(3'h2, 2'h1);
    ex(BALU_OP_ACC_ADD_FILE, 1'b1, 1'b0, 8'h05, n);
    rdc(fa(5), 32'hFF, 32'h1A);
    rdc(BALU_ACC_OFS, 32'hFF, 32'h10);
    st(3'h0, 2'h1);
    wr(BALU_STATUS_OFS, 32'h1);
    wr(BALU_ACC_OFS, 32'hFF);
    wr(fa(9), 32'h00);
    ex(BALU_OP_ACC_ADD_FILE_WITH_CARRY, 1'b1, 1'b0, 8'h09, n);
    rdc(fa(9), 32'hFF, 32'h00);
    st(3'h7, 2'h1);
  endtask

  task automatic t_and();
    wr(BALU_STATUS_OFS, 32'h3);
    wr(BALU_ACC_OFS, 32'hF0);
    ex(BALU_OP_ACC_AND_IMMEDIATE, 1'b0, 1'b0, 8'h0F, n);
    rdc(BALU_ACC_OFS, 32'hFF, 32'h00);
    st(3'h7, 2'h1);
    wr(BALU_STATUS_OFS, 32'h3);
    wr(BALU_ACC_OFS, 32'h3C);
    wr(fa(7), 32'h0F);
    ex(BALU_OP_ACC_AND_FILE, 1'b1, 1'b0, 8'h07, n);
    rdc(fa(7), 32'hFF, 32'h0C);
    st(3'h3, 2'h1);
  endtask

  task automatic t_asr();
    wr(BALU_STATUS_OFS, 32'h2);
    wr(fa(3), 32'h81);
    ex(BALU_OP_ARITH_SHIFT_RIGHT_FILE, 1'b0, 1'b0, 8'h03, n);
    rdc(BALU_ACC_OFS, 32'hFF, 32'hC0);
    st(3'h3, 2'h1);
    wr(BALU_STATUS_OFS, 32'h0);
    wr(fa(4), 32'h01);
    ex(BALU_OP_ARITH_SHIFT_RIGHT_FILE, 1'b1, 1'b0, 8'h04, n);
    rdc(fa(4), 32'hFF, 32'h00);
    st(3'h5, 2'h1);
  endtask

  task automatic t_cyc();
    wr(BALU_PTR0_OFS, 32'h8005);
    wr(BALU_ACC_OFS, 32'h01);
    ex(BALU_OP_ACC_ADD_FILE, 1'b0, 1'b0, 8'h00, n);
    chk(n, 32'h2);
    rdc(BALU_ACC_OFS, 32'hFF, 32'h1B);
    ex(BALU_OP_IDLE_CYCLE, 1'b0, 1'b1, 8'h00, n);
    chk(n, 32'h2);
    st(3'h0, 2'h2);
    wr(BALU_PTR1_OFS, 32'h8007);
    ex(BALU_OP_ACC_AND_FILE, 1'b0, 1'b1, 8'h01, n);
    chk(n, 32'h3);
    st(3'h0, 2'h3);
    wr(BALU_PTR0_OFS, 32'h0005);
    ex(BALU_OP_ACC_ADD_FILE, 1'b0, 1'b0, 8'h00, n);
    chk(n, 32'h1);
  endtask

  // a write chained straight behind the instruction meets busy and must be ignored
  task automatic t_refuse();
    logic [31:0] r;
    logic e;
    apb(1'b0, 12'h014, 32'h0, r, e);
    rel();
    chk({31'h0, e}, 32'h1);
    wr(BALU_PTR0_OFS, 32'h8005);
    wr(BALU_ACC_OFS, 32'h00);
    apb(1'b1, BALU_EXEC_OFS, {24'h0, 3'h0, 1'b1, 1'b0, BALU_OP_ACC_ADD_FILE}, r, e);
    apb(1'b1, BALU_ACC_OFS, 32'h55, r, e);
    rel();
    chk({31'h0, e}, 32'h1);
    repeat (20) begin
      @(posedge sys_clk);
      if (busy === 1'b0) break;
    end
    rdc(BALU_ACC_OFS, 32'hFF, 32'h1A);
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    rdc(BALU_ACC_OFS, 32'hFFFF_FFFF, 32'h0);
    st(3'h0, 2'h1);
    rdc(BALU_PTR1_OFS, 32'hFFFF_FFFF, 32'h0);
    t_ptr();
    t_add();
    t_and();
    t_asr();
    t_cyc();
    t_refuse();
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    err_count++;
    stop_test();
  end
endmodule
